// ===== common/tms_defs.svh
/*
 * constants of the multiframe sink: label byte fields, alignment and
 * pointer counts, frame timing, register offsets and reset values.
 * assumes a byte-wide path stream with one label byte at frame start.
 */
`ifndef TMS_DEFS_SVH
`define TMS_DEFS_SVH
// ====================================================================
// label byte fields (bit 7 is the msb)
`define TMS_LBL_HI 5
`define TMS_LBL_LO 3
`define TMS_MF_HI 2
`define TMS_MF_LO 1
`define TMS_EXP_LABEL 3'h3
// ====================================================================
// alignment, acceptance and timing
`define TMS_IM_FRAMES 4
`define TMS_LBL_ACCEPT 3
`define TMS_FRAME_US 125
`define TMS_LOM_MS 3
`define TMS_LOM_FRAMES (`TMS_LOM_MS * 1000 / `TMS_FRAME_US)
`define TMS_NUM_SLOTS 14
`define TMS_PTR_MAX 139
`define TMS_PI_NORM_CNT 3
`define TMS_PI_AIS_CNT 3
`define TMS_PI_LOP_CNT 8
// ====================================================================
// register byte offsets and reset values
`define TMS_A_CTRL 12'h000
`define TMS_A_SINK_ACT 12'h004
`define TMS_A_AIS_REP 12'h008
`define TMS_A_STATUS 12'h00C
`define TMS_A_LOP_FLT 12'h010
`define TMS_A_AIS_FLT 12'h014
`define TMS_A_INT_STAT 12'h018
`define TMS_A_INT_MASK 12'h01C
`define TMS_CTRL_RST 1'h1
`define TMS_INT_BITS 4
`endif

// ===== common/tms_pkg.sv
/*
 * shared types of the multiframe sink.
 * assumes nothing beyond the defs header for widths.
 */
package tms_pkg;
    // ================================================================
    // aligner and pointer interpreter states
    typedef enum logic [0:0] {TMS_OOM, TMS_IM} tms_mf_e;
    typedef enum logic [1:0] {TMS_NORM, TMS_AIS, TMS_LOP} tms_ptr_e;
    // path byte as it leaves the pin synchroniser
    typedef struct packed {
        logic [7:0] data;
        logic       fs;
        logic       tsf;
    } tms_byte_s;
    // aligner status toward the rest of the chain
    typedef struct packed {
        logic       in_mf;
        logic [1:0] phase;
        logic       plm_def;
        logic       lom_def;
        logic       plm_fault;
        logic       lom_fault;
        logic       server_signal_fail;
    } tms_mfa_s;
    // client side of one tu sink
    typedef struct packed {
        logic [7:0] data;
        logic       vld;
        logic       v5;
        logic       server_signal_fail;
    } tms_client_s;
endpackage

// ===== rtl/tms_mfa.sv
/*
 * label check and multiframe aligner, run once per label byte.
 * assumes byte_vld pulses one cycle per path byte, fs marks the label.
 */
`timescale 1ns/1ps
`include "tms_defs.svh"
module tms_mfa (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // path byte stream
    input  wire logic             byte_vld,
    input  tms_pkg::tms_byte_s    in_byte,
    // management
    input  wire logic             activate,
    output tms_pkg::tms_mfa_s     status
);
    typedef struct packed {
        tms_pkg::tms_mf_e  st;
        logic [1:0]        last;
        logic [2:0]        good;
        logic [4:0]        out_of_multiframe_state;
        logic [2:0]        cand;
        logic [1:0]        lcnt;
        logic [2:0]        acc;
        logic              acc_ok;
        tms_pkg::tms_mfa_s o;
    } tms_mfa_state_s;
    tms_mfa_state_s r, n;
    logic [1:0] code;
    logic [2:0] lbl;
    logic       good;

    assign code = in_byte.data[`TMS_MF_HI:`TMS_MF_LO];
    assign lbl  = in_byte.data[`TMS_LBL_HI:`TMS_LBL_LO];
    assign good = (code == r.last + 2'h1);
    assign status = r.o;

    // ================================================================
    // alignment, acceptance and defects
    always_comb begin
        n = r;
        if (byte_vld && in_byte.fs) begin
            n.last = code;
            n.o.phase = code - 2'h1;
            if (lbl == r.cand) begin
                if (r.lcnt != 2'(`TMS_LBL_ACCEPT)) n.lcnt = r.lcnt + 2'h1;
            end else begin
                n.cand = lbl;
                n.lcnt = 2'h1;
            end
            if (n.lcnt == 2'(`TMS_LBL_ACCEPT)) begin
                n.acc = lbl;
                n.acc_ok = 1'b1;
            end
            if (r.st == tms_pkg::TMS_IM) begin
                if (!good) begin
                    n.st = tms_pkg::TMS_OOM;
                    n.good = 3'h0;
                end
            end else begin
                n.good = good ? r.good + 3'h1 : 3'h0;
                if (n.good == 3'(`TMS_IM_FRAMES)) n.st = tms_pkg::TMS_IM;
            end
            // frame counter is the millisecond timer
            if (n.st == tms_pkg::TMS_IM) begin
                n.out_of_multiframe_state = 5'h0;
                n.o.lom_def = 1'b0;
            end else if (r.out_of_multiframe_state != 5'(`TMS_LOM_FRAMES)) begin
                n.out_of_multiframe_state = r.out_of_multiframe_state + 5'h1;
            end else begin
                n.o.lom_def = 1'b1;
            end
        end
        n.o.in_mf = (n.st == tms_pkg::TMS_IM);
        n.o.plm_def = n.acc_ok && (n.acc != `TMS_EXP_LABEL);
        n.o.server_signal_fail = !activate || n.o.plm_def || n.o.lom_def;
        n.o.plm_fault = activate && n.o.plm_def && !in_byte.tsf;
        n.o.lom_fault = activate && n.o.lom_def && !in_byte.tsf
                        && !n.o.plm_def;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) r <= '0;
        else r <= n;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_oom_on_error: assert property (
        byte_vld && in_byte.fs && r.st == tms_pkg::TMS_IM && !good
        |=> !status.in_mf) else $error("aligner kept sync on error");
    a_im_after_four: assert property (
        $rose(status.in_mf) |-> $past(r.good) == 3'(`TMS_IM_FRAMES - 1))
        else $error("in-multiframe without four good frames");
    a_inactive_quiet: assert property (
        !activate |=> status.server_signal_fail && !status.plm_fault && !status.lom_fault)
        else $error("inactive stage not failing quietly");
    a_lom_cleared: assert property (
        status.in_mf |-> !status.lom_def) else $error("loss kept in sync");
endmodule

// ===== rtl/tms_tu_sink.sv
/*
 * one tu-12 sink: pointer interpretation, all-ones and fault report.
 * assumes the top hands it every payload byte with its slot number.
 */
`timescale 1ns/1ps
`include "tms_defs.svh"
module tms_tu_sink #(
    parameter int TU_INDEX = 0
) (
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // payload stream
    input  wire logic          tu_vld,
    input  wire logic [7:0]    tu_data,
    input  wire logic [3:0]    tu_slot,
    input  wire logic          tu_first,
    input  wire logic [1:0]    phase,
    input  wire logic          tsf,
    // management
    input  wire logic          activate,
    input  wire logic          ais_rep,
    output logic               ais_fault,
    output logic               lop_fault,
    // client
    output tms_pkg::tms_client_s client
);
    typedef struct packed {
        tms_pkg::tms_ptr_e   ps;
        logic [7:0]          v1;
        logic [9:0]          cand;
        logic [9:0]          ptr;
        logic [9:0]          idx;
        logic [2:0]          cnt;
        logic [1:0]          kind;
        tms_pkg::tms_client_s o;
    } tms_sink_state_s;
    tms_sink_state_s r, n;
    logic       mine;
    logic [9:0] pv;
    logic       force1;

    assign mine = tu_vld && (tu_slot == 4'(TU_INDEX));
    assign pv = {r.v1[1:0], tu_data};
    assign force1 = !activate || r.ps != tms_pkg::TMS_NORM || tsf;
    assign client = r.o;
    assign ais_fault = activate && r.ps == tms_pkg::TMS_AIS && !tsf
                       && ais_rep;
    assign lop_fault = activate && r.ps == tms_pkg::TMS_LOP && !tsf;

    // ================================================================
    // pointer interpreter and client byte
    always_comb begin
        n = r;
        n.o.vld = 1'b0;
        n.o.v5 = 1'b0;
        n.o.server_signal_fail = force1;
        if (mine && tu_first && phase == 2'h0) n.v1 = tu_data;
        if (mine && tu_first && phase == 2'h1) begin
            n.idx = 10'h0;
            // pointer class: 1 all-ones, 2 valid, 3 invalid
            if (r.v1 == 8'hFF && tu_data == 8'hFF) begin
                n.kind = 2'h1;
            end else if (pv <= 10'(`TMS_PTR_MAX)) begin
                n.kind = 2'h2;
                n.cand = pv;
            end else begin
                n.kind = 2'h3;
            end
            // a run counts while class repeats and, for a valid pointer, its value
            if (n.kind != r.kind || (n.kind == 2'h2 && pv != r.cand)) begin
                n.cnt = 3'h1;
            end else if (r.cnt != 3'h7) begin
                n.cnt = r.cnt + 3'h1;
            end
            if (n.kind == 2'h1 && n.cnt >= 3'(`TMS_PI_AIS_CNT)) begin
                n.ps = tms_pkg::TMS_AIS;
            end
            if (n.kind == 2'h2 && n.cnt >= 3'(`TMS_PI_NORM_CNT)) begin
                n.ps = tms_pkg::TMS_NORM;
                n.ptr = pv;
            end
            if (n.kind == 2'h3 && r.kind == 2'h3
                && r.cnt == 3'(`TMS_PI_LOP_CNT - 1)) begin
                n.ps = tms_pkg::TMS_LOP;
            end
        end else if (mine && !(tu_first && phase == 2'h0)) begin
            n.o.vld = 1'b1;
            n.o.v5 = (r.idx == r.ptr) && !force1;
            n.o.data = force1 ? 8'hFF : tu_data;
            n.idx = r.idx + 10'h1;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) r <= '{ps: tms_pkg::TMS_LOP, o: '{8'hFF, 1'b0, 1'b0,
                             1'b1}, default: '0};
        else r <= n;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_force_ones: assert property (
        mine && force1 |=> client.vld -> client.data == 8'hFF)
        else $error("data passed while all-ones forced");
    a_ais_option: assert property (
        ais_fault |-> ais_rep && !tsf) else $error("all_ones_report_enable unasked");
    a_inactive_mute: assert property (
        !activate |-> !ais_fault && !lop_fault)
        else $error("inactive sink reports status");
endmodule

// ===== rtl/tms_top.sv
/*
 * multiframe sink chain: pin synchroniser, label and multiframe stage,
 * virtual termination, tu-12 sinks and an apb register file.
 * assumes path pins from another clock domain, apb master on pclk.
 */
`timescale 1ns/1ps
`include "tms_defs.svh"
module tms_top #(
    parameter int NUM_SINKS = `TMS_NUM_SLOTS
) (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic [11:0]          paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // path pins
    input  wire logic                 path_ck,
    input  wire logic [7:0]           path_data,
    input  wire logic                 path_fs,
    input  wire logic                 path_tsf,
    // downstream
    output tms_pkg::tms_client_s [NUM_SINKS-1:0] client,
    output logic                      trail_fail_action,
    output logic                      irq
);
    localparam int N = NUM_SINKS;
    localparam int IB = `TMS_INT_BITS;

    typedef struct packed {
        logic [10:0]  s1;
        logic [10:0]  s2;
        logic         ck_d;
        logic         vld;
        tms_pkg::tms_byte_s b;
        logic [3:0]   slot;
        logic [3:0]   nxt;
        logic         first;
        logic         first_pend;
        logic         act;
        logic [N-1:0] sink_act;
        logic [N-1:0] ais_rep;
        logic [IB-1:0] ist;
        logic [IB-1:0] imask;
        logic [IB-1:0] ev_d;
        logic [31:0]  rd;
    } tms_top_state_s;
    tms_top_state_s r, n;

    tms_pkg::tms_mfa_s mfa;
    logic [N-1:0]      lop_f;
    logic [N-1:0]      ais_f;
    logic [IB-1:0]     ev;
    logic              wr;
    logic              hit;
    logic [31:0]       rmux;
    logic [31:0]       stat_word;

    // ================================================================
    // label and multiframe stage
    tms_mfa u_mfa (
        .pclk     (pclk),
        .presetn  (presetn),
        .byte_vld (r.vld),
        .in_byte  (r.b),
        .activate (r.act),
        .status   (mfa)
    );

    // virtual termination: stream passes, trail fail mirrors server fail
    assign trail_fail_action = mfa.server_signal_fail;

    // ================================================================
    // tu sinks, one per timeslot
    genvar gi;
    generate
        for (gi = 0; gi < N; gi = gi + 1) begin : g_sink
            tms_tu_sink #(
                .TU_INDEX (gi)
            ) u_sink (
                .pclk      (pclk),
                .presetn   (presetn),
                .tu_vld    (r.vld && !r.b.fs),
                .tu_data   (r.b.data),
                .tu_slot   (r.slot),
                .tu_first  (r.first),
                .phase     (mfa.phase),
                .tsf       (trail_fail_action),
                .activate  (r.sink_act[gi]),
                .ais_rep   (r.ais_rep[gi]),
                .ais_fault (ais_f[gi]),
                .lop_fault (lop_f[gi]),
                .client    (client[gi])
            );
        end
    endgenerate

    // ================================================================
    // apb decode and read mux
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign prdata = r.rd;
    assign stat_word = {28'h0, trail_fail_action, mfa.in_mf,
                        mfa.lom_fault, mfa.plm_fault};

    // register read selection
    always_comb begin
        hit = 1'b1;
        rmux = 32'h0;
        case (paddr)
            `TMS_A_CTRL:     rmux = {31'h0, r.act};
            `TMS_A_SINK_ACT: rmux = 32'(r.sink_act);
            `TMS_A_AIS_REP:  rmux = 32'(r.ais_rep);
            `TMS_A_STATUS:   rmux = stat_word;
            `TMS_A_LOP_FLT:  rmux = 32'(lop_f);
            `TMS_A_AIS_FLT:  rmux = 32'(ais_f);
            `TMS_A_INT_STAT: rmux = 32'(r.ist);
            `TMS_A_INT_MASK: rmux = 32'(r.imask);
            default:         hit = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !hit;

    // events: rising edges of the reported faults
    assign ev = {|ais_f, |lop_f, mfa.lom_fault, mfa.plm_fault};
    assign irq = |(r.ist & r.imask);

    // ================================================================
    // pin sampling, byte framing and registers
    always_comb begin
        n = r;
        // two-stage synchroniser; s1 is read only by s2
        n.s1 = {path_ck, path_fs, path_tsf, path_data};
        n.s2 = r.s1;
        n.ck_d = r.s2[10];
        n.vld = 1'b0;
        if (r.s2[10] && !r.ck_d) begin
            n.vld = 1'b1;
            n.b.fs = r.s2[9];
            n.b.tsf = r.s2[8];
            n.b.data = r.s2[7:0];
            if (r.s2[9]) begin
                n.nxt = 4'h0;
                n.first_pend = 1'b1;
            end else begin
                n.slot = r.nxt;
                n.first = r.first_pend;
                if (r.nxt == 4'(`TMS_NUM_SLOTS - 1)) begin
                    n.nxt = 4'h0;
                    n.first_pend = 1'b0;
                end else begin
                    n.nxt = r.nxt + 4'h1;
                end
            end
        end
        // read data captured in the setup phase
        if (psel && !penable) n.rd = rmux;
        if (wr && paddr == `TMS_A_CTRL) n.act = pwdata[0];
        if (wr && paddr == `TMS_A_SINK_ACT) n.sink_act = pwdata[N-1:0];
        if (wr && paddr == `TMS_A_AIS_REP) n.ais_rep = pwdata[N-1:0];
        if (wr && paddr == `TMS_A_INT_MASK) n.imask = pwdata[IB-1:0];
        if (wr && paddr == `TMS_A_INT_STAT) n.ist = r.ist & ~pwdata[IB-1:0];
        // set wins over a simultaneous clear
        n.ev_d = ev;
        n.ist = n.ist | (ev & ~r.ev_d);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) r <= '{act: `TMS_CTRL_RST, default: '0};
        else r <= n;
    end

    // ================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_byte_on_edge: assert property (
        r.vld |-> $past(r.s2[10]) && !$past(r.ck_d))
        else $error("byte taken without path clock edge");
    a_tsf_to_sinks: assert property (
        $rose(mfa.server_signal_fail) |-> trail_fail_action ##1
        (client[0].server_signal_fail || !r.sink_act[0]))
        else $error("trail fail not passed to sinks");
    a_slot_range: assert property (
        r.vld && !r.b.fs |-> r.slot < 4'(`TMS_NUM_SLOTS))
        else $error("slot out of range");
    a_event_sticky: assert property (
        $rose(ev[0]) |=> r.ist[0] ##1 r.ist[0])
        else $error("plm event lost");
    a_lom_no_plm: assert property (
        mfa.lom_fault |-> !mfa.plm_fault)
        else $error("loss reported under mismatch");

    c_in_mf: cover property ($rose(mfa.in_mf));
    c_lom: cover property ($rose(mfa.lom_fault));
    c_irq: cover property ($rose(irq));
    c_err: cover property (pslverr);

endmodule

// ===== testbench/tms_path_model.sv
/*
 * upstream path layer model: sends label byte then 28 payload bytes.
 * assumes a 64 ns byte clock that stands still between frames.
 */
`timescale 1ns/1ps
module tms_path_model (
    // path pins
    output logic       path_ck,
    output logic [7:0] path_data,
    output logic       path_fs
);
    // ================================================================
    // idle pins until the first frame
    initial begin
        path_ck = 1'b0;
        path_data = 8'hA5;
        path_fs = 1'b0;
    end
    // one byte, stable around the rising byte clock
    task automatic send_byte(input logic [7:0] d, input logic fs);
        #5;
        path_data = d;
        path_fs = fs;
        #27 path_ck = 1'b1;
        #32 path_ck = 1'b0;
    endtask
    // label byte, then slot k carries 8'h50 + k unless a pointer byte
    task automatic send_frame(input logic [2:0] lbl, input logic [1:0] code,
                              input logic use_v, input logic [7:0] v);
        int i;
        send_byte({2'b00, lbl, code, 1'b0}, 1'b1);
        for (i = 0; i < 28; i++) begin
            send_byte((use_v && i < 14) ? v : 8'h50 + 8'(i % 14), 1'b0);
        end
        path_data = ~path_data; // released lines do not keep the value
        path_fs = 1'b0;
    endtask
    // whole multiframes, codes 01 10 11 00, pointer in frames 0 and 1
    task automatic send_mf(input logic [2:0] lbl, input logic [7:0] v1,
                           input logic [7:0] v2, input int n);
        int f;
        repeat (n) begin
            for (f = 0; f < 4; f++) begin
                send_frame(lbl, 2'(f + 1), f < 2, f == 0 ? v1 : v2);
            end
        end
    endtask
endmodule

// ===== testbench/tb_top.sv
/*
 * self-checking bench of the multiframe sink chain over apb and path.
 * assumes zero-wait apb slave and a path model driving the pins.
 */
`timescale 1ns/1ps
`include "tms_defs.svh"
module tb_top;
    logic                        pclk = 1'b0;
    logic                        presetn = 1'b0;
    logic [11:0]                 paddr = 12'h000;
    logic                        psel = 1'b0;
    logic                        penable = 1'b0;
    logic                        pwrite = 1'b0;
    logic [31:0]                 pwdata = 32'h0;
    logic                        pready;
    logic [31:0]                 prdata;
    logic                        pslverr;
    logic                        path_ck;
    logic [7:0]                  path_data;
    logic                        path_fs;
    logic                        path_tsf = 1'b0;
    tms_pkg::tms_client_s [13:0] client;
    logic                        trail_fail_action;
    logic                        irq;
    logic [31:0]                 rd;
    logic                        err;
    int                          miscompares = 0;
    int                          checks = 0;
    // ================================================================
    // clock, model and design
    always #4 pclk = ~pclk;
    tms_path_model path_u (.path_ck(path_ck), .path_data(path_data),
                           .path_fs(path_fs));
    tms_top #(.NUM_SINKS(14)) dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .path_ck(path_ck), .path_data(path_data), .path_fs(path_fs),
        .path_tsf(path_tsf), .client(client),
        .trail_fail_action(trail_fail_action), .irq(irq));
    // ================================================================
    // verdict and comparison
    task automatic summarize;
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // one multiframe while sink 0 bytes are compared
    task automatic watch(input logic [7:0] v1, input logic [7:0] v2,
                         input logic [7:0] d, input logic s, input int e5);
        int n;
        int seen;
        int v5n;
        seen = 0;
        v5n = 0;
        fork
            path_u.send_mf(3'h3, v1, v2, 1);
            for (n = 0; n < 900; n++) begin
                @(negedge pclk);
                if (client[0].v5 === 1'b1) v5n++;
                if (client[0].vld === 1'b1) begin
                    seen++;
                    chk(32'(client[0].data), 32'(d));
                    chk(32'(client[0].server_signal_fail), 32'(s));
                end
            end
        join
        chk(32'(seen > 0), 32'h1);
        chk(32'(v5n), 32'(e5));
    endtask
    // ================================================================
    // scenarios
    task automatic t_reset;
        rdchk(`TMS_A_CTRL, 32'h1);
        rdchk(`TMS_A_AIS_REP, 32'h0);
        rdchk(`TMS_A_SINK_ACT, 32'h0);
        rdchk(`TMS_A_INT_MASK, 32'h0);
        apb(1'b1, `TMS_A_STATUS, 32'hFFFFFFFF);
        rdchk(`TMS_A_STATUS, 32'h0);
        rdchk(12'h040, 32'h0);
        chk(32'(err), 32'h1);
    endtask
    task automatic t_lom;
        apb(1'b1, `TMS_A_INT_MASK, 32'h2);
        repeat (25) path_u.send_frame(3'h3, 2'h1, 1'b0, 8'h00);
        rdchk(`TMS_A_STATUS, 32'hA);
        chk(32'(irq), 32'h1);
        apb(1'b1, `TMS_A_INT_STAT, 32'h2);
        @(negedge pclk);
        chk(32'(irq), 32'h0);
    endtask
    task automatic t_sync;
        path_u.send_mf(3'h3, 8'h50, 8'h50, 2);
        rdchk(`TMS_A_STATUS, 32'h4);
        chk(32'(trail_fail_action), 32'h0);
        path_u.send_frame(3'h3, 2'h3, 1'b0, 8'h00);
        rdchk(`TMS_A_STATUS, 32'h0);
        path_u.send_mf(3'h3, 8'h50, 8'h50, 2);
        rdchk(`TMS_A_STATUS, 32'h4);
    endtask
    task automatic t_label;
        path_u.send_mf(3'h2, 8'h50, 8'h50, 2);
        rdchk(`TMS_A_STATUS, 32'hD);
        chk(32'(trail_fail_action), 32'h1);
        @(posedge pclk) path_tsf <= 1'b1;
        path_u.send_mf(3'h2, 8'h50, 8'h50, 1);
        rdchk(`TMS_A_STATUS, 32'hC);
        @(posedge pclk) path_tsf <= 1'b0;
        path_u.send_mf(3'h3, 8'h50, 8'h50, 1);
        rdchk(`TMS_A_STATUS, 32'h4);
    endtask
    task automatic t_act;
        apb(1'b1, `TMS_A_CTRL, 32'h0);
        path_u.send_mf(3'h2, 8'h50, 8'h50, 1);
        chk(32'(trail_fail_action), 32'h1);
        apb(1'b0, `TMS_A_STATUS, 32'h0);
        chk(32'(rd[1:0]), 32'h0);
        apb(1'b1, `TMS_A_CTRL, 32'h1);
        path_u.send_mf(3'h3, 8'h50, 8'h50, 2);
    endtask
    task automatic t_sink;
        apb(1'b1, `TMS_A_SINK_ACT, 32'h1);
        path_u.send_mf(3'h3, 8'h00, 8'h05, 4);
        watch(8'h00, 8'h05, 8'h50, 1'b0, 1);
        rdchk(`TMS_A_LOP_FLT, 32'h0);
        path_u.send_mf(3'h3, 8'hFF, 8'hFF, 4);
        watch(8'hFF, 8'hFF, 8'hFF, 1'b1, 0);
        rdchk(`TMS_A_AIS_FLT, 32'h0);
        apb(1'b1, `TMS_A_AIS_REP, 32'h1);
        path_u.send_mf(3'h3, 8'hFF, 8'hFF, 1);
        rdchk(`TMS_A_AIS_FLT, 32'h1);
        apb(1'b1, `TMS_A_INT_STAT, 32'hF);
        path_u.send_mf(3'h3, 8'h03, 8'hFF, 9);
        rdchk(`TMS_A_LOP_FLT, 32'h1);
        apb(1'b0, `TMS_A_INT_STAT, 32'h0);
        chk(32'(rd[2]), 32'h1);
        chk(32'(client[0].data), 32'hFF);
        apb(1'b1, `TMS_A_SINK_ACT, 32'h0);
        path_u.send_mf(3'h3, 8'h03, 8'hFF, 1);
        rdchk(`TMS_A_LOP_FLT, 32'h0);
        chk(32'(client[0].data), 32'hFF);
        chk(32'(client[1].data), 32'hFF);
    endtask
    // ================================================================
    // reset, then the scenarios in order
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_lom();
        t_sync();
        t_label();
        t_act();
        t_sink();
        summarize();
    end
endmodule
